/* sgow_regs.svh */
`ifndef SGOW_REGS_SVH
`define SGOW_REGS_SVH
// register byte offsets
`define SGOW_CTRL_OFS 4'h0
`define SGOW_WAIT_OFS 4'h4
`define SGOW_STAT_OFS 4'h8
// control register fields
`define SGOW_CTRL_MODE_LSB 0
`define SGOW_CTRL_STBY_LSB 4
`define SGOW_CTRL_MOSC_BIT 8
`define SGOW_CTRL_MRC_BIT 9
`define SGOW_CTRL_SOSC_BIT 10
`define SGOW_CTRL_SRC_BIT 11
`define SGOW_CTRL_HIZ_BIT 12
// wait time register fields and power-on value
`define SGOW_WAIT_MAIN_LSB 0
`define SGOW_WAIT_SUB_LSB 4
`define SGOW_WAIT_POR 8'hFF
// status register fields
`define SGOW_STAT_STBY_LSB 4
`define SGOW_STAT_STAB_LSB 8
`define SGOW_STAT_RUN_LSB 12
`define SGOW_STAT_BUSY_BIT 16
// clock mode codes, also oscillator index
`define SGOW_MODE_MAIN 2'h0
`define SGOW_MODE_MRC 2'h1
`define SGOW_MODE_SUB 2'h2
`define SGOW_MODE_SRC 2'h3
// standby request codes
`define SGOW_STBY_RUN 2'h0
`define SGOW_STBY_SLEEP 2'h1
`define SGOW_STBY_TIMER 2'h2
`define SGOW_STBY_STOP 2'h3
// rc settle counts in reference cycles
`define SGOW_MRC_WAIT 16'h0100
`define SGOW_SRC_WAIT 16'h0020
`define SGOW_AXI_OKAY 2'h0
`define SGOW_AXI_SLVERR 2'h2
`endif

/* sgow_pkg.sv */
package sgow_pkg;
  // standby state, one-hot
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_TIMER = 4'b0100,
    ST_STOP = 4'b1000
  } sgow_stby_t;
  // clock supply enables towards the core
  typedef struct packed {
    logic cpu;
    logic swdt;
    logic periph;
    logic tbt;
    logic wpre;
    logic hwdt;
    logic port_hold;
    logic port_hiz;
  } sgow_gate_t;
  // machine clock selection
  typedef struct packed {
    logic [1:0] src;
    logic div2;
  } sgow_mclk_t;
endpackage

/* sgow_clk_ctrl.sv */
`timescale 1ns/1ps
`include "sgow_regs.svh"
module sgow_clk_ctrl
  import sgow_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic [3:0] osc_clk_in,
  input wire logic wake_irq,
  input wire logic hwdt_stby_off,
  input wire logic hwdt_started,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] osc_run_q,
  output sgow_gate_t gate_q,
  output sgow_mclk_t mclk_q
);

  // ************************************************************
  // helper functions
  // ************************************************************

  // oscillator wait length from a four-bit select code
  function automatic logic [CW-1:0] osc_wait_len(input logic [3:0] sel, input logic is_sub);
    logic [4:0] e;
    e = is_sub ? {1'b0, sel} : ({1'b0, sel} - 5'h01);
    if ((is_sub && sel < 4'h2) || (!is_sub && sel < 4'h3)) begin
      osc_wait_len = '0;
    end else begin
      osc_wait_len = CW'((32'h1 << e) - 32'h2);
    end
  endfunction

  // standby state to status code
  function automatic logic [1:0] stby_code(input sgow_stby_t s);
    unique case (s)
      ST_RUN: stby_code = `SGOW_STBY_RUN;
      ST_SLEEP: stby_code = `SGOW_STBY_SLEEP;
      ST_TIMER: stby_code = `SGOW_STBY_TIMER;
      ST_STOP: stby_code = `SGOW_STBY_STOP;
      default: stby_code = `SGOW_STBY_RUN;
    endcase
  endfunction

  // main or main rc mode
  function automatic logic is_main(input logic [1:0] m);
    is_main = (m == `SGOW_MODE_MAIN) || (m == `SGOW_MODE_MRC);
  endfunction

  // ************************************************************
  // input synchronisers and oscillator edge detect
  // ************************************************************

  logic [3:0] osc_s1_q; // first stage, read only by second
  logic [3:0] osc_s2_q; // settled oscillator level
  logic [3:0] osc_s3_q; // delayed copy for edges
  logic [3:0] osc_edge; // one rising edge per oscillator
  logic [1:0] wake_s_q; // wake request synchroniser
  logic [1:0] hoff_s_q; // watchdog strap synchroniser

  // oscillators are far slower than core_clk, so sampling is enough
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_s1_q <= 4'h0;
      osc_s2_q <= 4'h0;
      osc_s3_q <= 4'h0;
      wake_s_q <= 2'h0;
      hoff_s_q <= 2'h0;
    end else begin
      osc_s1_q <= osc_clk_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      wake_s_q <= {wake_s_q[0], wake_irq};
      hoff_s_q <= {hoff_s_q[0], hwdt_stby_off};
    end
  end

  assign osc_edge = osc_s2_q & ~osc_s3_q;

  // ************************************************************
  // software registers
  // ************************************************************

  logic [15:0] ctrl_q; // clock mode request, standby, enables
  logic [7:0] wsel_q; // wait time selects
  logic [1:0] cur_mode_q; // clock mode in effect
  sgow_stby_t stby_q; // standby state
  logic [3:0] stable_q; // settle done per oscillator
  logic [CW-1:0] cnt_q [4]; // dedicated settle counters
  logic aw_have_q; // write address held
  logic w_have_q; // write data held
  logic [3:0] awaddr_q; // latched write address
  logic [31:0] wdata_q; // latched write data
  logic [3:0] wstrb_q; // latched byte strobes
  logic wr_fire; // both halves present, do the write
  logic [1:0] req_mode; // requested clock mode
  logic [3:0] run_d; // oscillator run next value
  logic [CW-1:0] len [4]; // settle length per oscillator
  logic busy; // some settle in progress

  assign req_mode = ctrl_q[`SGOW_CTRL_MODE_LSB +: 2];
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************

  // address and data are taken in either order, one write at a time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SGOW_AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // status is read-only, writes there are refused too
        s_axi_bresp <= (awaddr_q == `SGOW_CTRL_OFS || awaddr_q == `SGOW_WAIT_OFS)
                       ? `SGOW_AXI_OKAY : `SGOW_AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ready only while the slot is free, so the master is stalled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !wr_fire;
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !wr_fire;
    end
  end

  // control register; a warm reset restores mode but not waits
  always_ff @(posedge core_clk) begin
    if (rst || soft_rst) begin
      ctrl_q <= 16'h0000;
    end else if (wr_fire && awaddr_q == `SGOW_CTRL_OFS) begin
      if (wstrb_q[0]) begin
        ctrl_q[7:0] <= wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
        ctrl_q[15:8] <= wdata_q[15:8];
      end
    end else if (stby_q != ST_RUN) begin
      // standby request is a one-shot, clear once taken
      ctrl_q[`SGOW_CTRL_STBY_LSB +: 2] <= `SGOW_STBY_RUN;
    end
  end

  // wait selects: power-on forces longest, warm reset keeps them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wsel_q <= `SGOW_WAIT_POR;
    end else if (wr_fire && awaddr_q == `SGOW_WAIT_OFS && wstrb_q[0]) begin
      wsel_q <= wdata_q[7:0];
    end
  end

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************

  // one read under way at a time, answered the cycle after arvalid
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SGOW_AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SGOW_AXI_OKAY;
        unique case (s_axi_araddr)
          `SGOW_CTRL_OFS: s_axi_rdata <= {16'h0, ctrl_q};
          `SGOW_WAIT_OFS: s_axi_rdata <= {24'h0, wsel_q};
          `SGOW_STAT_OFS: begin
            s_axi_rdata <= 32'h0;
            s_axi_rdata[1:0] <= cur_mode_q;
            s_axi_rdata[`SGOW_STAT_STBY_LSB +: 2] <= stby_code(stby_q);
            s_axi_rdata[`SGOW_STAT_STAB_LSB +: 4] <= stable_q;
            s_axi_rdata[`SGOW_STAT_RUN_LSB +: 4] <= osc_run_q;
            s_axi_rdata[`SGOW_STAT_BUSY_BIT] <= busy;
          end
          default: begin
            // unmapped: zero data with an error answer
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SGOW_AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // standby state machine
  // ************************************************************

  // entered from run on a software request, left on a wake request
  always_ff @(posedge core_clk) begin
    if (rst || soft_rst) begin
      stby_q <= ST_RUN;
    end else begin
      unique case (stby_q)
        ST_RUN: begin
          unique case (ctrl_q[`SGOW_CTRL_STBY_LSB +: 2])
            `SGOW_STBY_SLEEP: stby_q <= ST_SLEEP;
            `SGOW_STBY_TIMER: stby_q <= ST_TIMER;
            `SGOW_STBY_STOP: stby_q <= ST_STOP;
            default: stby_q <= ST_RUN;
          endcase
        end
        ST_SLEEP, ST_TIMER, ST_STOP: begin
          if (wake_s_q[1]) begin
            stby_q <= ST_RUN;
          end
        end
        default: stby_q <= ST_RUN;
      endcase
    end
  end

  // ************************************************************
  // oscillator run control
  // ************************************************************

  // the requested mode's oscillator is started ahead of the switch
  always_comb begin
    logic stop;
    stop = (stby_q == ST_STOP);
    run_d[`SGOW_MODE_MAIN] = !stop && ((cur_mode_q == `SGOW_MODE_MAIN) ||
      (cur_mode_q == `SGOW_MODE_MRC && ctrl_q[`SGOW_CTRL_MOSC_BIT]) ||
      (req_mode == `SGOW_MODE_MAIN));
    run_d[`SGOW_MODE_MRC] = !stop && ((cur_mode_q == `SGOW_MODE_MRC) ||
      (cur_mode_q == `SGOW_MODE_MAIN && ctrl_q[`SGOW_CTRL_MRC_BIT]) ||
      (req_mode == `SGOW_MODE_MRC));
    run_d[`SGOW_MODE_SUB] = (ctrl_q[`SGOW_CTRL_SOSC_BIT] || cur_mode_q == `SGOW_MODE_SUB ||
      req_mode == `SGOW_MODE_SUB) && !(stop && !is_main(cur_mode_q));
    run_d[`SGOW_MODE_SRC] = (ctrl_q[`SGOW_CTRL_SRC_BIT] || cur_mode_q == `SGOW_MODE_SRC ||
      req_mode == `SGOW_MODE_SRC) && !(stop && !is_main(cur_mode_q));
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_run_q <= 4'h0;
    end else begin
      osc_run_q <= run_d;
    end
  end

  // ************************************************************
  // oscillation settle counters
  // ************************************************************

  assign len[`SGOW_MODE_MAIN] = osc_wait_len(wsel_q[`SGOW_WAIT_MAIN_LSB +: 4], 1'b0);
  assign len[`SGOW_MODE_MRC] = CW'(`SGOW_MRC_WAIT);
  assign len[`SGOW_MODE_SUB] = osc_wait_len(wsel_q[`SGOW_WAIT_SUB_LSB +: 4], 1'b1);
  assign len[`SGOW_MODE_SRC] = CW'(`SGOW_SRC_WAIT);

  // a stopped oscillator loses its settle; restart counts afresh
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stable_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!osc_run_q[i]) begin
          stable_q[i] <= 1'b0;
          cnt_q[i] <= '0;
        end else if (!stable_q[i]) begin
          if (cnt_q[i] >= len[i]) begin
            stable_q[i] <= 1'b1;
          end else if (osc_edge[i] && !(i == 2 && osc_run_q[0] && !stable_q[0])) begin
            cnt_q[i] <= cnt_q[i] + CW'(1);
          end
        end
      end
    end
  end

  // an oscillator running or about to start and not settled blocks all supply but hwdt, port hold and hi-z, so no open cycle before its enable lands
  assign busy = |((osc_run_q | run_d) & ~stable_q);

  // ************************************************************
  // clock mode switch
  // ************************************************************

  // switch only once the target is settled; settled targets go at once
  always_ff @(posedge core_clk) begin
    if (rst || soft_rst) begin
      cur_mode_q <= `SGOW_MODE_MAIN;
    end else if (req_mode != cur_mode_q && stby_q == ST_RUN && stable_q[req_mode]) begin
      cur_mode_q <= req_mode;
    end
  end

  // machine clock source; crystal sources are halved
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mclk_q <= '0;
    end else begin
      mclk_q.src <= cur_mode_q;
      mclk_q.div2 <= !cur_mode_q[0];
    end
  end

  // ************************************************************
  // clock supply gating
  // ************************************************************

  // supply enables from standby state, clock mode and settle state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gate_q <= '0;
    end else begin
      gate_q.cpu <= !busy && stby_q == ST_RUN;
      gate_q.swdt <= !busy && stby_q == ST_RUN;
      gate_q.periph <= !busy && (stby_q == ST_RUN || stby_q == ST_SLEEP);
      gate_q.tbt <= !busy && is_main(cur_mode_q) && stby_q != ST_STOP;
      gate_q.wpre <= !busy && (stby_q == ST_STOP
        ? (is_main(cur_mode_q) && (ctrl_q[`SGOW_CTRL_SOSC_BIT] || ctrl_q[`SGOW_CTRL_SRC_BIT]))
        : (!is_main(cur_mode_q) || ctrl_q[`SGOW_CTRL_SOSC_BIT] ||
           ctrl_q[`SGOW_CTRL_SRC_BIT]));
      gate_q.hwdt <= hwdt_started && !(stby_q != ST_RUN && hoff_s_q[1]);
      gate_q.port_hold <= stby_q != ST_RUN;
      gate_q.port_hiz <= (stby_q == ST_TIMER || stby_q == ST_STOP) &&
        ctrl_q[`SGOW_CTRL_HIZ_BIT];
    end
  end

endmodule // sgow_clk_ctrl

/* sgow_clk_ctrl_monitor.sv */
`timescale 1ns/1ps
// ****************************************
// gating and oscillator checker
// ****************************************
module sgow_clk_ctrl_monitor
  import sgow_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hwdt_stby_off,
  input wire logic hwdt_started,
  input wire logic [3:0] osc_run_q,
  input wire sgow_gate_t gate_q,
  input wire sgow_mclk_t mclk_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // a running cpu means the software watchdog and peripherals are fed too, ports not held
  run_supply_a: assert property (gate_q.cpu |-> gate_q.swdt && gate_q.periph && !gate_q.port_hold)
    else $error("cpu supplied without full run supply");
  // peripherals without cpu is sleep: watchdog off, ports held
  sleep_gate_a: assert property (gate_q.periph && !gate_q.cpu |-> !gate_q.swdt && gate_q.port_hold)
    else $error("sleep supply wrong");
  // time-base timer alone: only timer standby, cpu side dark
  timer_gate_a: assert property (gate_q.tbt && !gate_q.periph |-> !gate_q.cpu && !gate_q.swdt)
    else $error("timer standby supply wrong");
  // the time-base timer never runs in the sub modes
  tbt_main_a: assert property (gate_q.tbt |-> !mclk_q.src[1])
    else $error("time-base timer fed in sub mode");
  // main and sub modes divide by two, rc modes pass straight
  mclk_div_a: assert property (gate_q.cpu |-> mclk_q.div2 == !mclk_q.src[0])
    else $error("machine clock divide wrong");
  // the selected source must be oscillating while it feeds the cpu
  sel_osc_a: assert property (gate_q.cpu |-> osc_run_q[mclk_q.src])
    else $error("selected oscillator not running");
  // both main oscillators rest in the sub modes once the switch has settled
  sub_main_off_a: assert property (gate_q.cpu && $past(gate_q.cpu) && mclk_q.src[1] |->
    osc_run_q[1:0] == 2'h0)
    else $error("main oscillator running in sub mode");
  // a freshly started main rc or sub oscillator withdraws the cpu supply quickly
  start_wait_a: assert property (|(osc_run_q[2:1] & ~$past(osc_run_q[2:1])) |-> ##[1:3] !gate_q.cpu)
    else $error("supply kept during oscillator start");
  // a started watchdog not disabled in standby keeps its clock
  hwdt_run_a: assert property ((hwdt_started && !hwdt_stby_off) [*5] |-> gate_q.hwdt)
    else $error("hardware watchdog clock missing");
  sleep_c: cover property (gate_q.periph && !gate_q.cpu);
  watch_c: cover property (gate_q.wpre && !gate_q.periph && mclk_q.src[1]);
  stop_c: cover property (osc_run_q == 4'h0 && !gate_q.cpu);
endmodule // sgow_clk_ctrl_monitor

bind sgow_clk_ctrl sgow_clk_ctrl_monitor i_mon (.core_clk(core_clk), .rst(rst), .hwdt_stby_off(hwdt_stby_off),
  .hwdt_started(hwdt_started), .osc_run_q(osc_run_q), .gate_q(gate_q), .mclk_q(mclk_q));

/* tb.sv */
`timescale 1ns/1ps
`include "sgow_regs.svh"
// ****************************************
// testbench
// ****************************************
module tb;
  import sgow_pkg::*;
  logic core_clk, rst, soft_rst, wake_irq, hwdt_stby_off, hwdt_started, ph;
  logic [3:0] osc_clk_in, osc_run_q, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  sgow_gate_t gate_q;
  sgow_mclk_t mclk_q;
  int n_errors, total_checks, e, n;
  int edges [4]; // rising edges made per oscillator

  sgow_clk_ctrl i_dut (.core_clk, .rst, .soft_rst, .osc_clk_in, .wake_irq, .hwdt_stby_off, .hwdt_started,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_run_q, .gate_q, .mclk_q);

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // oscillators toggle every two cycles while enabled; a stopped one sits low
  always @(posedge core_clk) begin
    ph <= ~ph;
    if (!ph) begin
      osc_clk_in <= ~osc_clk_in & osc_run_q;
      for (int i = 0; i < 4; i++)
        if (!osc_clk_in[i] && osc_run_q[i]) edges[i] <= edges[i] + 1;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // write: both channels offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rdr(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask

  // bounded wait for the cpu supply to reach a level
  task automatic wait_cpu(input logic want, input int lim);
    n = 0;
    while (gate_q.cpu !== want && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    check("cpu wait", n < lim, 1'b1);
    // clock select and oscillator enables follow the supply by an edge or two
    repeat (3) @(posedge core_clk);
  endtask

  // enter a standby, judge gates and oscillators, then wake by interrupt
  task automatic stby(input logic [31:0] ctl, input logic [3:0] run, input logic [7:0] msk, gexp, input int lim);
    wr(`SGOW_CTRL_OFS, ctl);
    repeat (4) @(posedge core_clk);
    check("standby osc", osc_run_q, run);
    check("standby gates", gate_q & msk, gexp);
    wake_irq <= 1'b1;
    wait_cpu(1'b1, lim);
    wake_irq <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask

  initial begin
    {rst, hwdt_started} = 2'b11;
    {soft_rst, wake_irq, hwdt_stby_off, ph} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, osc_clk_in, s_axi_wdata} = 44'h0;
    s_axi_wstrb = 4'hF;
    edges = '{default: 0};
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    // power-on: default main wait before any supply
    e = edges[0];
    repeat (2) @(posedge core_clk);
    check("por osc", osc_run_q, 4'h1);
    wait_cpu(1'b1, 70000);
    check("por wait", (edges[0] - e) inside {[16382:16386]}, 1'b1);
    check("mclk main", mclk_q, {`SGOW_MODE_MAIN, 1'b1});
    rdr(`SGOW_WAIT_OFS);
    check("wait reset", rd, 32'h000000FF);
    wr(`SGOW_WAIT_OFS, 32'h00000024);
    rdr(`SGOW_WAIT_OFS);
    check("wait field", rd, 32'h00000024);
    // main rc start waits its reference count
    e = edges[1];
    wr(`SGOW_CTRL_OFS, 32'h00000001);
    wait_cpu(1'b0, 20);
    wait_cpu(1'b1, 2000);
    check("mrc wait", (edges[1] - e) inside {[256:260]}, 1'b1);
    check("mclk mrc", mclk_q, {`SGOW_MODE_MRC, 1'b0});
    check("mrc osc", osc_run_q, 4'h2);
    // warm reset restarts main with the programmed wait
    e = edges[0];
    soft_rst <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
    wait_cpu(1'b0, 20);
    wait_cpu(1'b1, 300);
    check("warm wait", (edges[0] - e) inside {[6:10]}, 1'b1);
    check("mclk warm", mclk_q, {`SGOW_MODE_MAIN, 1'b1});
    stby(32'h00000010, 4'h1, 8'hFF, 8'h36, 20);
    check("run gates", gate_q, 8'hF4);
    // sub mode uses the programmed sub wait
    e = edges[2];
    wr(`SGOW_CTRL_OFS, 32'h00000002);
    wait_cpu(1'b0, 20);
    wait_cpu(1'b1, 300);
    check("sub wait", (edges[2] - e) inside {[2:5]}, 1'b1);
    check("mclk sub", mclk_q, {`SGOW_MODE_SUB, 1'b1});
    check("sub osc", osc_run_q, 4'h4);
    // watch mode keeps the sub oscillator, so wake needs no wait
    stby(32'h00001022, 4'h4, 8'hFD, 8'h0D, 8);
    hwdt_stby_off <= 1'b1;
    repeat (4) @(posedge core_clk);
    stby(32'h00000032, 4'h0, 8'hFC, 8'h00, 300);
    check("stop wake osc", osc_run_q, 4'h4);
    hwdt_stby_off <= 1'b0;
    // sub rc mode waits its own short count, then the sub oscillator rests
    e = edges[3];
    wr(`SGOW_CTRL_OFS, 32'h00000003);
    wait_cpu(1'b0, 20);
    wait_cpu(1'b1, 300);
    check("src wait", (edges[3] - e) inside {[32:36]}, 1'b1);
    check("mclk src", mclk_q, {`SGOW_MODE_SRC, 1'b0});
    check("src osc", osc_run_q, 4'h8);
    rdr(`SGOW_STAT_OFS);
    check("status", rd, 32'h00008803);
    // unmapped and read-only places are refused
    rdr(4'hC);
    check("unmapped data", rd, 32'h0);
    check("unmapped resp", rs, `SGOW_AXI_SLVERR);
    wr(`SGOW_STAT_OFS, 32'h0);
    check("status write", rs, `SGOW_AXI_SLVERR);
    results();
  end

  // watchdog: the whole run needs about 70k cycles
  initial begin
    repeat (90000) @(posedge core_clk);
    n_errors++;
    $display("unexpected timeout: expected finish seen hang");
    results();
  end
endmodule // tb
